//--- hw/lpmc_pkg.sv
// Package of constants and types for the low-power mode controller
package lpmc_pkg;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFS_IRQ_EN = 12'h00c;
  localparam logic [11:0] OFS_IRQ_CLR = 12'h010;
  localparam logic [11:0] OFS_EVT_EN = 12'h014;
  // Control field positions
  localparam int CTRL_REQ_SLEEP = 0;
  localparam int CTRL_REQ_STOP = 1;
  localparam int CTRL_REQ_STBY = 2;
  localparam int CTRL_STOP_LPR = 3;
  localparam int CTRL_SVM_EN = 4;
  // Interrupt bit positions and width
  localparam int IRQ_WAKE_SLEEP = 0;
  localparam int IRQ_WAKE_STOP = 1;
  localparam int IRQ_SVM = 2;
  localparam int IRQ_W = 3;
  // Reset values
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] EVT_EN_RST = 16'hffff;
  // Cycles from entry to the Standby wake qualifier being armed
  localparam logic [3:0] STBY_ARM_CYC = 4'h2;

  typedef enum logic [1:0] {
    LPMC_REG_MAIN,
    LPMC_REG_LOW,
    LPMC_REG_OFF
  } lpmc_reg_t;

  typedef enum {
    LPMC_RUN,
    LPMC_SLEEP,
    LPMC_STOP,
    LPMC_STBY
  } lpmc_mode_t;

  // Wakeup sources seen by the controller
  typedef struct packed {
    logic [15:0] ext_lines;
    logic supply_voltage_monitor;
    logic rtc_alarm;
    logic periph_irq;
    logic wakeup_pin;
    logic external_reset_pin_n;
    logic independent_watchdog_rst;
  } lpmc_wake_t;

  // Power and clock controls to the rest of the chip
  typedef struct packed {
    logic cpu_clk_en;
    logic core_clk_en;
    logic pll_en;
    logic internal_fast_oscillator_en;
    logic external_fast_oscillator_en;
    logic core_power_en;
    logic retain_en;
    logic rtc_wdg_run;
    logic [1:0] reg_state;
  } lpmc_pwr_t;
endpackage

//--- hw/lpmc_edge.sv
// Rising-edge detector for one level input
`timescale 1ns/10ps
`default_nettype none
module lpmc_edge (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Level in, pulse out
  input wire logic lvl,
  output logic rise
);
  logic prev_q;

  assign rise = lvl & ~prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= lvl;
    end
  end
endmodule
`default_nettype wire

//--- hw/lpmc_irq.sv
// Sticky interrupt status with enable and write-one clear
`timescale 1ns/10ps
`default_nettype none
module lpmc_irq #(
  parameter int W = 3
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // Events and software access
  input wire logic [W-1:0] evt,
  input wire logic [W-1:0] clr,
  input wire logic [W-1:0] en,
  // Status and interrupt
  output logic [W-1:0] stat,
  output logic irq
);
  logic [W-1:0] stat_q;
  logic [W-1:0] stat_d;

  if (W < 1) begin : g_chk
    $error("lpmc_irq needs W of at least 1");
  end

  // Set wins over a clear in the same cycle
  assign stat_d = (stat_q & ~clr) | evt;
  assign stat = stat_q;
  assign irq = |(stat_q & en);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= stat_d;
    end
  end
endmodule
`default_nettype wire

//--- hw/lpmc_top.sv
// Low-power mode controller with APB registers
`timescale 1ns/10ps
`default_nettype none
module lpmc_top #(
  parameter int N_EXT = 16
) (
  // Clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Wakeup sources
  input wire lpmc_pkg::lpmc_wake_t wake,
  // Power controls
  output lpmc_pkg::lpmc_pwr_t pwr,
  output logic core_reset_req,
  output logic irq
);
  if (N_EXT != 16) begin : g_chk
    $error("lpmc_top supports exactly 16 external lines");
  end

  lpmc_pkg::lpmc_mode_t mode_q;
  lpmc_pkg::lpmc_mode_t mode_d;
  logic [4:0] ctrl_q;
  logic [15:0] evt_en_q;
  logic [lpmc_pkg::IRQ_W-1:0] irq_en_q;
  logic [lpmc_pkg::IRQ_W-1:0] irq_stat;
  logic [lpmc_pkg::IRQ_W-1:0] irq_evt;
  logic [lpmc_pkg::IRQ_W-1:0] irq_clr;
  logic [3:0] arm_q;
  logic rst_req_q;
  logic [31:0] prdata_q;
  lpmc_pkg::lpmc_pwr_t pwr_q;
  lpmc_pkg::lpmc_pwr_t pwr_d;

  // Bus decode
  wire acc = psel & penable & ce;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_ctrl = paddr == lpmc_pkg::OFS_CTRL;
  wire hit_stat = paddr == lpmc_pkg::OFS_STAT;
  wire hit_ist = paddr == lpmc_pkg::OFS_IRQ_STAT;
  wire hit_ien = paddr == lpmc_pkg::OFS_IRQ_EN;
  wire hit_iclr = paddr == lpmc_pkg::OFS_IRQ_CLR;
  wire hit_evt = paddr == lpmc_pkg::OFS_EVT_EN;
  wire hit_any = hit_ctrl | hit_stat | hit_ist | hit_ien | hit_iclr | hit_evt;

  // Wake qualifiers
  wire svm_live = ctrl_q[lpmc_pkg::CTRL_SVM_EN] & wake.supply_voltage_monitor;
  wire wake_pin_rise;
  wire stop_wake = |(wake.ext_lines & evt_en_q) | svm_live | wake.rtc_alarm;
  wire sleep_wake = wake.periph_irq | stop_wake;
  wire stby_armed = arm_q == lpmc_pkg::STBY_ARM_CYC;
  wire stby_wake = stby_armed & (~wake.external_reset_pin_n | wake.independent_watchdog_rst
    | wake_pin_rise | wake.rtc_alarm);

  lpmc_edge u_wakeup_pin (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .lvl(wake.wakeup_pin),
    .rise(wake_pin_rise)
  );

  // Mode sequencing
  always_comb begin
    mode_d = mode_q;
    unique case (mode_q)
      lpmc_pkg::LPMC_RUN: begin
        if (ctrl_q[lpmc_pkg::CTRL_REQ_STBY]) begin
          mode_d = lpmc_pkg::LPMC_STBY;
        end else if (ctrl_q[lpmc_pkg::CTRL_REQ_STOP]) begin
          mode_d = lpmc_pkg::LPMC_STOP;
        end else if (ctrl_q[lpmc_pkg::CTRL_REQ_SLEEP]) begin
          mode_d = lpmc_pkg::LPMC_SLEEP;
        end
      end
      lpmc_pkg::LPMC_SLEEP: begin
        if (sleep_wake) begin
          mode_d = lpmc_pkg::LPMC_RUN;
        end
      end
      lpmc_pkg::LPMC_STOP: begin
        if (stop_wake) begin
          mode_d = lpmc_pkg::LPMC_RUN;
        end
      end
      lpmc_pkg::LPMC_STBY: begin
        if (stby_wake) begin
          mode_d = lpmc_pkg::LPMC_RUN;
        end
      end
    endcase
  end

  // Power and clock controls per mode
  always_comb begin
    pwr_d = '0;
    pwr_d.rtc_wdg_run = 1'b1;
    pwr_d.core_power_en = 1'b1;
    pwr_d.retain_en = 1'b1;
    pwr_d.cpu_clk_en = 1'b1;
    pwr_d.core_clk_en = 1'b1;
    pwr_d.pll_en = 1'b1;
    pwr_d.internal_fast_oscillator_en = 1'b1;
    pwr_d.external_fast_oscillator_en = 1'b1;
    pwr_d.reg_state = lpmc_pkg::LPMC_REG_MAIN;
    unique case (mode_d)
      lpmc_pkg::LPMC_RUN: begin
      end
      lpmc_pkg::LPMC_SLEEP: begin
        pwr_d.cpu_clk_en = 1'b0;
      end
      lpmc_pkg::LPMC_STOP: begin
        pwr_d.cpu_clk_en = 1'b0;
        pwr_d.core_clk_en = 1'b0;
        pwr_d.pll_en = 1'b0;
        pwr_d.internal_fast_oscillator_en = 1'b0;
        pwr_d.external_fast_oscillator_en = 1'b0;
        pwr_d.reg_state = ctrl_q[lpmc_pkg::CTRL_STOP_LPR] ? lpmc_pkg::LPMC_REG_LOW
          : lpmc_pkg::LPMC_REG_MAIN;
      end
      lpmc_pkg::LPMC_STBY: begin
        pwr_d.cpu_clk_en = 1'b0;
        pwr_d.core_clk_en = 1'b0;
        pwr_d.pll_en = 1'b0;
        pwr_d.internal_fast_oscillator_en = 1'b0;
        pwr_d.external_fast_oscillator_en = 1'b0;
        pwr_d.core_power_en = 1'b0;
        pwr_d.retain_en = 1'b0;
        pwr_d.reg_state = lpmc_pkg::LPMC_REG_OFF;
      end
    endcase
  end

  assign pwr = pwr_q;
  assign core_reset_req = rst_req_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= lpmc_pkg::LPMC_RUN;
      pwr_q <= '{cpu_clk_en: 1'b1, core_clk_en: 1'b1, pll_en: 1'b1,
        internal_fast_oscillator_en: 1'b1, external_fast_oscillator_en: 1'b1,
        core_power_en: 1'b1, retain_en: 1'b1, rtc_wdg_run: 1'b1,
        reg_state: lpmc_pkg::LPMC_REG_MAIN};
      rst_req_q <= 1'b0;
      arm_q <= 4'h0;
    end else if (ce) begin
      mode_q <= mode_d;
      pwr_q <= pwr_d;
      rst_req_q <= (mode_q == lpmc_pkg::LPMC_STBY) & stby_wake;
      if (mode_q == lpmc_pkg::LPMC_STBY && !stby_armed) begin
        arm_q <= arm_q + 4'h1;
      end else if (mode_q != lpmc_pkg::LPMC_STBY) begin
        arm_q <= 4'h0;
      end
    end
  end

  // Control register; requests self-clear on entry, Standby wake resets it
  wire entering = (mode_q == lpmc_pkg::LPMC_RUN) & (mode_d != lpmc_pkg::LPMC_RUN);
  wire [4:0] ctrl_d = (wr & hit_ctrl) ? pwdata[4:0]
    : entering ? (ctrl_q & 5'h18) : ctrl_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= lpmc_pkg::CTRL_RST;
      evt_en_q <= lpmc_pkg::EVT_EN_RST;
      irq_en_q <= '0;
    end else if (ce) begin
      if (rst_req_q) begin
        ctrl_q <= lpmc_pkg::CTRL_RST;
        evt_en_q <= lpmc_pkg::EVT_EN_RST;
        irq_en_q <= '0;
      end else begin
        ctrl_q <= ctrl_d;
        if (wr & hit_evt) begin
          evt_en_q <= pwdata[15:0];
        end
        if (wr & hit_ien) begin
          irq_en_q <= pwdata[lpmc_pkg::IRQ_W-1:0];
        end
      end
    end
  end

  // Interrupt events
  assign irq_evt[lpmc_pkg::IRQ_WAKE_SLEEP] = (mode_q == lpmc_pkg::LPMC_SLEEP) & sleep_wake;
  assign irq_evt[lpmc_pkg::IRQ_WAKE_STOP] = (mode_q == lpmc_pkg::LPMC_STOP) & stop_wake;
  assign irq_evt[lpmc_pkg::IRQ_SVM] = svm_live;
  assign irq_clr = (wr & hit_iclr) ? pwdata[lpmc_pkg::IRQ_W-1:0] : '0;

  lpmc_irq #(
    .W(lpmc_pkg::IRQ_W)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .evt(irq_evt),
    .clr(irq_clr),
    .en(irq_en_q),
    .stat(irq_stat),
    .irq(irq)
  );

  // Read data
  wire [31:0] rd_mux = hit_ctrl ? {27'h0, ctrl_q}
    : hit_stat ? {26'h0, pwr_q.reg_state, 2'h0, mode_q == lpmc_pkg::LPMC_STOP,
      mode_q == lpmc_pkg::LPMC_SLEEP}
    : hit_ist ? {29'h0, irq_stat}
    : hit_ien ? {29'h0, irq_en_q}
    : hit_evt ? {16'h0, evt_en_q} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (ce && psel && !penable && !pwrite) begin
      prdata_q <= rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // Assertions
  a_stop_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_STOP |-> !pwr_q.core_clk_en && !pwr_q.pll_en
    && pwr_q.retain_en) else $error("Stop clocks wrong");
  a_stby_reg_off: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_STBY |-> pwr_q.reg_state == lpmc_pkg::LPMC_REG_OFF
    && !pwr_q.core_power_en && !pwr_q.retain_en) else $error("Standby power wrong");
  a_run_main: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_RUN |-> pwr_q.reg_state == lpmc_pkg::LPMC_REG_MAIN
    && pwr_q.cpu_clk_en) else $error("Run regulator wrong");
  a_sleep_cpu: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_SLEEP |-> !pwr_q.cpu_clk_en && pwr_q.core_clk_en)
    else $error("Sleep clocks wrong");
  a_stop_lpr: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_STOP && ctrl_q[lpmc_pkg::CTRL_STOP_LPR]
    |-> pwr_q.reg_state == lpmc_pkg::LPMC_REG_LOW) else $error("Stop regulator wrong");
  a_stop_wake: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mode_q == lpmc_pkg::LPMC_STOP && wake.rtc_alarm |=> mode_q == lpmc_pkg::LPMC_RUN)
    else $error("Stop wake missed");
  a_stby_wake: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mode_q == lpmc_pkg::LPMC_STBY && stby_armed && !wake.external_reset_pin_n
    |=> rst_req_q && pwr_q.reg_state == lpmc_pkg::LPMC_REG_MAIN)
    else $error("Standby wake missed");
  a_rtc_run: assert property (@(posedge pclk) disable iff (!presetn)
    pwr_q.rtc_wdg_run) else $error("RTC domain stopped");
  a_reset_reg_on: assert property (@(posedge pclk) $rose(presetn)
    |-> pwr_q.reg_state == lpmc_pkg::LPMC_REG_MAIN) else $error("Regulator off after reset");
  a_reset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rst_req_q |=> !rst_req_q)
    else $error("Reset request longer than one cycle");
  a_ctrl_wake_rst: assert property (@(posedge pclk) disable iff (!presetn)
    ce && rst_req_q |=> ctrl_q == lpmc_pkg::CTRL_RST)
    else $error("Control not reset after Standby wake");
  a_sleep_wake: assert property (@(posedge pclk) disable iff (!presetn)
    ce && mode_q == lpmc_pkg::LPMC_SLEEP && wake.periph_irq |=> mode_q == lpmc_pkg::LPMC_RUN)
    else $error("Sleep wake missed");
  a_stop_osc: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_STOP |-> !pwr_q.internal_fast_oscillator_en
    && !pwr_q.external_fast_oscillator_en && !pwr_q.cpu_clk_en) else $error("Stop oscillators on");
  a_stby_clocks: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_STBY |-> !pwr_q.pll_en && !pwr_q.core_clk_en
    && !pwr_q.internal_fast_oscillator_en) else $error("Standby clocks on");
  a_stby_hold: assert property (@(posedge pclk) disable iff (!presetn)
    mode_q == lpmc_pkg::LPMC_STBY && !stby_armed |=> mode_q == lpmc_pkg::LPMC_STBY)
    else $error("Standby left before armed");
  a_svm_gate: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_q[lpmc_pkg::CTRL_SVM_EN] |-> !irq_evt[lpmc_pkg::IRQ_SVM])
    else $error("Monitor event while disabled");
endmodule
`default_nettype wire

//--- verification/lpmc_tb.sv
// Testbench for the low-power mode controller
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, core_reset_req, irq, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  lpmc_pkg::lpmc_wake_t wake;
  lpmc_pkg::lpmc_pwr_t pwr;
  int num_errors, samples_checked, seen;
  localparam logic [21:0] W_IDLE = 22'h000002;
  localparam logic [9:0] P_RUN = 10'h3fc;
  localparam logic [9:0] P_SLEEP = 10'h1fc;
  localparam logic [9:0] P_STOPL = 10'h01d;
  localparam logic [9:0] P_STOPM = 10'h01c;
  localparam logic [9:0] P_STBY = 10'h006;

  lpmc_top #(.N_EXT(16)) lpmc_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake(wake), .pwr(pwr), .core_reset_req(core_reset_req), .irq(irq));

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1)
      num_errors++;
    rd = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic step_chk(input string nm, input logic [9:0] exp);
    @(posedge pclk);
    #1;
    chk(nm, {22'h0, pwr}, {22'h0, exp});
  endtask

  task final_report;
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #(100 * 20000);
    num_errors++;
    final_report;
  end

  initial begin
    presetn = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    wake = W_IDLE;
    num_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge pclk);
    #1;
    chk("pwr_reset", {22'h0, pwr}, {22'h0, P_RUN});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, lpmc_pkg::OFS_EVT_EN, 32'h0);
    chk("evt_en_reset", rd, 32'h0000ffff);
    apb(1'b0, lpmc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    apb(1'b0, 12'h0fc, 32'h0);
    chk("unmapped_err", {31'h0, err_q}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    $display("test registers done");
    // Sleep then peripheral interrupt
    apb(1'b1, lpmc_pkg::OFS_CTRL, 32'h1);
    step_chk("pwr_sleep", P_SLEEP);
    apb(1'b0, lpmc_pkg::OFS_STAT, 32'h0);
    chk("stat_sleep", rd, 32'h1);
    wake.periph_irq <= 1'b1;
    step_chk("pwr_sleep_wake", P_RUN);
    @(posedge pclk);
    wake <= W_IDLE;
    $display("test sleep done");
    // Stop with each wake source
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, lpmc_pkg::OFS_CTRL, (i == 0) ? 32'h0a : (i == 1) ? 32'h02 : 32'h12);
      step_chk("pwr_stop", (i == 0) ? P_STOPL : P_STOPM);
      case (i)
        0: wake.ext_lines[15] <= 1'b1;
        1: wake.rtc_alarm <= 1'b1;
        default: wake.supply_voltage_monitor <= 1'b1;
      endcase
      step_chk("pwr_stop_wake", P_RUN);
      @(posedge pclk);
      wake <= W_IDLE;
    end
    $display("test stop done");
    // Interrupt status, enable, clear
    apb(1'b0, lpmc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq_stat", rd, 32'h7);
    #1;
    chk("irq_masked", {31'h0, irq}, 32'h0);
    apb(1'b1, lpmc_pkg::OFS_IRQ_EN, 32'h4);
    @(posedge pclk);
    #1;
    chk("irq_on", {31'h0, irq}, 32'h1);
    apb(1'b1, lpmc_pkg::OFS_IRQ_CLR, 32'h4);
    @(posedge pclk);
    #1;
    chk("irq_cleared", {31'h0, irq}, 32'h0);
    apb(1'b0, lpmc_pkg::OFS_IRQ_STAT, 32'h0);
    chk("irq_stat_clr", rd, 32'h3);
    $display("test interrupt done");
    // Standby with each exit source
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, lpmc_pkg::OFS_CTRL, 32'h14);
      step_chk("pwr_standby", P_STBY);
      repeat (3) @(posedge pclk);
      case (i)
        0: wake.external_reset_pin_n <= 1'b0;
        1: wake.independent_watchdog_rst <= 1'b1;
        2: wake.wakeup_pin <= 1'b1;
        default: wake.rtc_alarm <= 1'b1;
      endcase
      seen = 0;
      for (int k = 0; k < 6; k++) begin
        @(posedge pclk);
        wake <= W_IDLE;
        #1;
        if (core_reset_req === 1'b1)
          seen++;
      end
      chk("pwr_standby_wake", {22'h0, pwr}, {22'h0, P_RUN});
      chk("reset_pulses", seen, 32'h1);
      apb(1'b0, lpmc_pkg::OFS_CTRL, 32'h0);
      chk("ctrl_after_wake", rd, 32'h0);
    end
    $display("test standby done");
    final_report;
  end
endmodule
`default_nettype wire
